// ==== design/ocfh_pkg.sv ====
// Constants and types for the overcurrent fault and hiccup sequencer.
// Assumes one 50 MHz core clock and analog comparators outside.
package ocfh_pkg;
  localparam int CNT_W = 3;
  localparam logic [2:0] CNT_FULL = 3'h7;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam int CLK_MHZ = 50;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    OCFH_SOFTSTART = 2'b00,
    OCFH_RUN = 2'b01,
    OCFH_DISCHARGE = 2'b10,
    OCFH_RECHARGE = 2'b11
  } ocfh_state_e;
endpackage

// ==== design/ocfh_sync_if.sv ====
// Bundle of synchronised comparator levels passed from the input stage.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
interface ocfh_sync_if;
  logic cycle_start;
  logic over_thresh;
  logic hs_on;
  logic cap_empty;
  logic cap_full;
  logic ss_done;
  logic shutdown;
  modport src (output cycle_start, over_thresh, hs_on, cap_empty, cap_full, ss_done, shutdown);
  modport dst (input cycle_start, over_thresh, hs_on, cap_empty, cap_full, ss_done, shutdown);
endinterface

// ==== design/ocfh_input_sync.sv ====
// Two-stage synchronisers for all analog comparator inputs.
// Assumes the inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module ocfh_input_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [6:0] async_in,
  ocfh_sync_if.src out
);
  typedef struct packed {
    logic [6:0] meta;
    logic [6:0] sync;
  } ocfh_sync_s;
  ocfh_sync_s st_ff;
  ocfh_sync_s nxt_st;
  always_comb begin
    nxt_st.meta = async_in;
    nxt_st.sync = st_ff.meta;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign out.cycle_start = st_ff.sync[0];
  assign out.over_thresh = st_ff.sync[1];
  assign out.hs_on = st_ff.sync[2];
  assign out.cap_empty = st_ff.sync[3];
  assign out.cap_full = st_ff.sync[4];
  assign out.ss_done = st_ff.sync[5];
  assign out.shutdown = st_ff.sync[6];
endmodule

// ==== design/ocfh_top.sv ====
// Overcurrent fault counter and hiccup sequencer for a buck controller.
// Assumes analog comparators and the PWM oscillator drive the inputs.
`timescale 1ns/1ns
module ocfh_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pwm_cycle_start,
  input wire logic pwm_request,
  input wire logic current_threshold_pin,
  input wire logic hs_on_sense,
  input wire logic softstart_cap_voltage,
  input wire logic cap_full_sense,
  input wire logic softstart_done_sense,
  input wire logic softstart_shutdown_pin,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic softstart_discharge,
  output logic fault_active,
  output logic [2:0] oc_count
);
  ocfh_sync_if sif ();
  ocfh_input_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({softstart_shutdown_pin, softstart_done_sense, cap_full_sense,
      softstart_cap_voltage, hs_on_sense, current_threshold_pin, pwm_cycle_start}),
    .out(sif)
  );

  typedef struct packed {
    ocfh_pkg::ocfh_state_e state;
    logic [2:0] cnt;
    logic cyc_dly;
    logic oc_seen;
    logic pulse_cut;
    logic hs;
    logic ls;
    logic dis;
    logic flt;
  } ocfh_top_s;
  ocfh_top_s st_ff;
  ocfh_top_s nxt_st;

  function automatic logic [2:0] sat_step(input logic [2:0] v, input logic up);
    if (up) begin
      sat_step = (v == ocfh_pkg::CNT_FULL) ? v : v + 3'h1;
    end else begin
      sat_step = (v == ocfh_pkg::CNT_ZERO) ? v : v - 3'h1;
    end
  endfunction

  logic cyc_edge;
  logic oc_now;
  logic switching;
  assign cyc_edge = sif.cycle_start & ~st_ff.cyc_dly;
  assign oc_now = sif.over_thresh & sif.hs_on;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cyc_dly = sif.cycle_start;
    switching = 1'b0;
    // New cycle clears first, so an overcurrent landing on the edge is not lost
    if (cyc_edge) begin
      nxt_st.oc_seen = 1'b0;
      nxt_st.pulse_cut = 1'b0;
    end
    if (oc_now) begin
      nxt_st.oc_seen = 1'b1;
      nxt_st.pulse_cut = 1'b1;
    end
    case (st_ff.state)
      ocfh_pkg::OCFH_SOFTSTART: begin
        switching = 1'b1;
        nxt_st.dis = 1'b0;
        if (sif.ss_done) begin
          nxt_st.state = ocfh_pkg::OCFH_RUN;
          nxt_st.oc_seen = 1'b0;
        end
      end
      ocfh_pkg::OCFH_RUN: begin
        switching = 1'b1;
        if (cyc_edge) begin
          nxt_st.cnt = sat_step(st_ff.cnt, st_ff.oc_seen);
          if (st_ff.oc_seen && st_ff.cnt == 3'h6 || st_ff.cnt == ocfh_pkg::CNT_FULL) begin
            nxt_st.state = ocfh_pkg::OCFH_DISCHARGE;
            nxt_st.flt = 1'b1;
            nxt_st.dis = 1'b1;
            nxt_st.cnt = sat_step(ocfh_pkg::CNT_FULL, 1'b0);
            switching = 1'b0;
          end
        end
      end
      ocfh_pkg::OCFH_DISCHARGE: begin
        nxt_st.dis = 1'b1;
        if (sif.cap_empty) begin
          nxt_st.dis = 1'b0;
          if (st_ff.cnt == ocfh_pkg::CNT_ZERO) begin
            nxt_st.state = ocfh_pkg::OCFH_SOFTSTART;
            nxt_st.flt = 1'b0;
          end else begin
            nxt_st.state = ocfh_pkg::OCFH_RECHARGE;
          end
        end
      end
      ocfh_pkg::OCFH_RECHARGE: begin
        nxt_st.dis = 1'b0;
        if (sif.cap_full) begin
          nxt_st.state = ocfh_pkg::OCFH_DISCHARGE;
          nxt_st.dis = 1'b1;
          nxt_st.cnt = sat_step(st_ff.cnt, 1'b0);
        end
      end
      default: begin
        nxt_st.state = ocfh_pkg::OCFH_SOFTSTART;
      end
    endcase
    // Shutdown pin high turns both gates off; outside a fault it also forces soft-start
    if (sif.shutdown) begin
      switching = 1'b0;
      if (!nxt_st.flt) begin
        nxt_st.state = ocfh_pkg::OCFH_SOFTSTART;
      end
    end
    nxt_st.hs = switching & pwm_request & ~nxt_st.pulse_cut & ~oc_now;
    nxt_st.ls = switching & ~nxt_st.hs;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign high_side_gate_drive = st_ff.hs;
  assign low_side_gate_drive = st_ff.ls;
  assign softstart_discharge = st_ff.dis;
  assign fault_active = st_ff.flt;
  assign oc_count = st_ff.cnt;

  chk_no_drive_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_ff.flt |=> !st_ff.hs && !st_ff.ls) else $error("gates on in fault");
  chk_count_sat_top: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_ff.cnt == 3'h7 |=> st_ff.cnt != 3'h0) else $error("count wrapped");
  chk_no_count_ss: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_ff.state == ocfh_pkg::OCFH_SOFTSTART |=> $stable(st_ff.cnt)) else $error("ss count");
  chk_fault_entry_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st_ff.flt) |-> st_ff.cnt == 3'h6 && st_ff.dis) else $error("bad entry");
  chk_recharge_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_ff.state == ocfh_pkg::OCFH_RECHARGE && sif.cap_full
      |=> st_ff.cnt == $past(st_ff.cnt) - 3'h1) else $error("no decrement");
  chk_empty_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_ff.state == ocfh_pkg::OCFH_DISCHARGE && sif.cap_empty |=> !st_ff.dis)
    else $error("discharge stuck");
  chk_fault_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(st_ff.flt) |-> st_ff.cnt == 3'h0 && st_ff.state == ocfh_pkg::OCFH_SOFTSTART)
    else $error("bad clear");
  chk_pulse_cut: assert property (@(posedge core_clk) disable iff (!rst_n)
    oc_now |=> !st_ff.hs) else $error("pulse not ended");
  chk_shutdown_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    sif.shutdown |=> !st_ff.hs && !st_ff.ls) else $error("switching in shutdown");
  chk_reset_clear: assert property (@(posedge core_clk)
    !rst_n |=> st_ff.cnt == ocfh_pkg::CNT_RESET && !st_ff.flt && !st_ff.dis && !st_ff.hs
      && !st_ff.ls && st_ff.state == ocfh_pkg::OCFH_SOFTSTART) else $error("reset left state");

  // Counter and hiccup steps, one sequence per step; recharge and run entry are checked inline
  sequence s_run_up;
    st_ff.state == ocfh_pkg::OCFH_RUN && cyc_edge && st_ff.oc_seen
      && st_ff.cnt != 3'h6;
  endsequence
  sequence s_run_down;
    st_ff.state == ocfh_pkg::OCFH_RUN && cyc_edge && !st_ff.oc_seen
      && st_ff.cnt != ocfh_pkg::CNT_ZERO;
  endsequence
  sequence s_run_floor;
    st_ff.state == ocfh_pkg::OCFH_RUN && cyc_edge && !st_ff.oc_seen
      && st_ff.cnt == ocfh_pkg::CNT_ZERO;
  endsequence
  sequence s_fault_entry;
    st_ff.state == ocfh_pkg::OCFH_RUN && cyc_edge && st_ff.oc_seen
      && st_ff.cnt == 3'h6;
  endsequence
  sequence s_fault_held;
    st_ff.flt && st_ff.state == ocfh_pkg::OCFH_DISCHARGE && st_ff.cnt == 3'h6
      && st_ff.dis && !st_ff.hs && !st_ff.ls;
  endsequence
  sequence s_empty_retry;
    st_ff.state == ocfh_pkg::OCFH_DISCHARGE && sif.cap_empty
      && st_ff.cnt != ocfh_pkg::CNT_ZERO;
  endsequence
  sequence s_empty_restart;
    st_ff.state == ocfh_pkg::OCFH_DISCHARGE && sif.cap_empty
      && st_ff.cnt == ocfh_pkg::CNT_ZERO;
  endsequence

  chk_count_up: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_run_up |=> st_ff.cnt == $past(st_ff.cnt) + 3'h1) else $error("no increment");
  chk_count_down: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_run_down |=> st_ff.cnt == $past(st_ff.cnt) - 3'h1) else $error("clean cycle kept count");
  chk_count_floor: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_run_floor |=> st_ff.cnt == ocfh_pkg::CNT_ZERO) else $error("count left zero");
  chk_fault_enter: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_fault_entry |=> s_fault_held) else $error("fault not entered");
  chk_empty_retry: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_empty_retry |=> st_ff.state == ocfh_pkg::OCFH_RECHARGE && !st_ff.dis && st_ff.flt)
    else $error("no recharge");
  chk_empty_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_empty_restart |=> st_ff.state == ocfh_pkg::OCFH_SOFTSTART && !st_ff.dis && !st_ff.flt)
    else $error("no restart");
  chk_cut_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_ff.pulse_cut && !cyc_edge |=> !st_ff.hs) else $error("pulse restarted");
  chk_run_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_ff.state == ocfh_pkg::OCFH_SOFTSTART && sif.ss_done && !sif.shutdown
      |=> st_ff.state == ocfh_pkg::OCFH_RUN && !st_ff.oc_seen) else $error("no run entry");
endmodule

// ==== sim/ocfh_stage_model.sv ====
// Power FETs and soft-start cap seen from the sequencer's pins.
// Assumes core_clk; the cap level is a coarse count, not a voltage.
`timescale 1ns/1ns
module ocfh_stage_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic high_side_gate_drive,
  input wire logic softstart_discharge,
  input wire logic short_on,
  output logic hs_on_sense,
  output logic current_threshold_pin,
  output logic softstart_cap_voltage,
  output logic cap_full_sense,
  output logic softstart_done_sense
);
  logic [6:0] lvl_ff;
  // Discharge is four times faster than charge, as a real switch would be
  always_ff @(posedge core_clk) begin
    if (!rst_n || softstart_discharge) begin
      lvl_ff <= (!rst_n || lvl_ff < 7'h04) ? 7'h00 : lvl_ff - 7'h04;
    end else if (lvl_ff < 7'h40) begin
      lvl_ff <= lvl_ff + 7'h01;
    end
  end
  assign hs_on_sense = high_side_gate_drive;
  // Overcurrent only shows while the high side conducts
  assign current_threshold_pin = short_on & high_side_gate_drive;
  assign softstart_cap_voltage = (lvl_ff == 7'h00);
  assign cap_full_sense = (lvl_ff == 7'h40);
  assign softstart_done_sense = (lvl_ff == 7'h40);
endmodule

// ==== sim/ocfh_top_bench.sv ====
// Self-checking bench for the overcurrent fault and hiccup sequencer.
// Assumes the stage model stands in for the FETs and soft-start cap.
`timescale 1ns/1ns
module ocfh_top_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic req = 1'b0;
  logic shrt = 1'b0;
  logic sd = 1'b0;
  logic hs, ct, ce, cf, sdn, hg, lg, dis, flt;
  logic [2:0] cnt;
  logic [3:0] last = 4'h0;
  logic [3:0] exq[$];
  logic [31:0] rs = 32'hAE2F;
  int err_total = 0;
  int n_tests = 0;
  int exp_c = 0;
  int n_faults = 0;
  int n;
  always #10 core_clk = ~core_clk;
  ocfh_top dut (.core_clk(core_clk), .rst_n(rst_n), .pwm_cycle_start(cyc), .pwm_request(req),
    .current_threshold_pin(ct), .hs_on_sense(hs), .softstart_cap_voltage(ce),
    .cap_full_sense(cf), .softstart_done_sense(sdn), .softstart_shutdown_pin(sd),
    .high_side_gate_drive(hg), .low_side_gate_drive(lg), .softstart_discharge(dis),
    .fault_active(flt), .oc_count(cnt));
  ocfh_stage_model stage (.core_clk(core_clk), .rst_n(rst_n), .high_side_gate_drive(hg),
    .softstart_discharge(dis), .short_on(shrt), .hs_on_sense(hs), .current_threshold_pin(ct),
    .softstart_cap_voltage(ce), .cap_full_sense(cf), .softstart_done_sense(sdn));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_gate(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t gates got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic note(input int c, input logic f);
    exq.push_back({f, 3'(c)});
  endtask
  // Short changes only while request is low, so no cycle sees both values
  task automatic pcycle(input logic s);
    @(posedge core_clk) #1;
    shrt = s;
    cyc = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 cyc = 1'b0;
    req = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 req = 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    if (rst_n && {flt, cnt} !== last) begin
      if (exq.size() == 0) chk({flt, cnt}, last);
      else chk({flt, cnt}, exq.pop_front());
      if (flt && !last[3]) begin
        n_faults++;
        chk_gate({dis, hg, lg}, 3'h4);
      end
    end
    if (flt) chk_gate({1'b0, hg, lg}, 3'h0);
    last <= {flt, cnt};
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk({flt, cnt}, 4'h0);
    for (int i = 0; i < 3; i++) pcycle(1'b1);
    for (int i = 0; i < 3; i++) pcycle(1'b0);
    $display("soft-start test done");
    for (int i = 0; i < 80 && exp_c < 7; i++) begin
      rs = xs(rs);
      n = (rs[1:0] != 2'b00) ? exp_c + 1 : (exp_c > 0 ? exp_c - 1 : 0);
      if (n == 7) begin
        note(6, 1'b1);
        for (int k = 5; k >= 0; k--) note(k, 1'b1);
        note(0, 1'b0);
      end else if (n != exp_c) begin
        note(n, 1'b0);
      end
      exp_c = n;
      pcycle(rs[1:0] != 2'b00);
    end
    for (int i = 0; i < 45; i++) pcycle(1'b0);
    #1 chk({1'b0, exq.size() == 0, flt, cnt == 3'h0}, 4'h5);
    chk({1'b0, 3'(n_faults)}, 4'h1);
    $display("fault and retry test done");
    sd = 1'b1;
    req = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 chk_gate({1'b0, hg, lg}, 3'h0);
    sd = 1'b0;
    req = 1'b0;
    $display("shutdown test done");
    results();
  end
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule
